// file: rtl/rsoa_pkg.sv
package rsoa_pkg;

  // ==========================================================
  // Clock and timing constants.
  // ==========================================================
  localparam int unsigned CORE_CLK_MHZ = 250;
  localparam int unsigned LOS_6312_NS  = 65000;   // Zero-run time in 6312 kHz mode, in ns.
  localparam int unsigned LOS_6312_CYC = (LOS_6312_NS * CORE_CLK_MHZ) / 1000;
  localparam int          TMR_W        = 15;
  localparam int          ZRUN_W       = 8;
  localparam int          TRANSMIT_CLOCK_LOSS_W       = 4;
  localparam logic [ZRUN_W-1:0] T1_LOS_ZEROS = 8'hc0;  // 192 zeros.
  localparam logic [ZRUN_W-1:0] E1_LOS_ZEROS = 8'hff;  // 255 zeros.
  localparam logic [TRANSMIT_CLOCK_LOSS_W-1:0] TRANSMIT_CLOCK_LOSS_PERIODS = 4'hf;   // 15 scaled master clock periods.
  localparam logic [7:0]        SCALE_DIV    = 8'h7a;  // Core cycles per scaled master tick.

  // ==========================================================
  // Register map, byte addresses on the Avalon-MM slave.
  // ==========================================================
  localparam int         ADDR_W       = 4;
  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_LIVE     = 4'h4;
  localparam logic [3:0] REG_INT_STAT = 4'h8;
  localparam logic [3:0] REG_INT_MASK = 4'hc;

  // ==========================================================
  // Modes, fields and state encodings.
  // ==========================================================
  typedef enum logic [1:0] {
    RSOA_MODE_T1   = 2'h0,
    RSOA_MODE_E1   = 2'h1,
    RSOA_MODE_6312 = 2'h2,
    RSOA_MODE_RSVD = 2'h3
  } rsoa_mode_t;

  // Control register, low bits of REG_CTRL.
  typedef struct packed {
    logic       frame_loss_function_select;  // 1 selects transmit clock loss.
    logic       signaling_double_pulse_bit;
    logic       boundary_select_bit;         // 1 selects multiframe boundaries.
    rsoa_mode_t mode;
  } rsoa_ctrl_t;
  localparam int         CTRL_W     = $bits(rsoa_ctrl_t);
  localparam rsoa_ctrl_t CTRL_RESET = '0;

  // Alarm conditions, shared by live, status and mask registers.
  typedef struct packed {
    logic tx_clk_loss;
    logic alarm_ind;
    logic signal_loss;
    logic frame_loss;
  } rsoa_alarm_t;
  localparam int ALARM_W = $bits(rsoa_alarm_t);

  // Inputs from the receive framer and the transmit clock pin.
  typedef struct packed {
    logic transmit_clock_in;
    logic clk;           // Recovered line clock.
    logic data;          // Recovered NRZ data.
    logic frame_start;
    logic mframe_start;
    logic sig_frame;     // Current frame carries signaling (T1).
    logic searching;     // Synchronizer is hunting for alignment.
    logic ais;           // Blue alarm (T1) or AIS (E1) detected.
  } rsoa_line_t;
  localparam int LINE_W = $bits(rsoa_line_t);

  typedef enum logic {
    RSOA_BUS_IDLE   = 1'b0,
    RSOA_BUS_ANSWER = 1'b1
  } rsoa_bus_st_t;

endpackage : rsoa_pkg

// file: rtl/rsoa_sync3.sv
`timescale 1ns/1ps
`default_nettype none
module rsoa_sync3
  import rsoa_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         core_clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] level_out
);
  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    logic [W-1:0] lvl;
  } rsoa_sync_st_t;

  rsoa_sync_st_t s_q;
  rsoa_sync_st_t s_d;

  // ==========================================================
  // Three-stage chain, a bit counts once stages two and three agree.
  // ==========================================================
  always_comb begin
    s_d     = s_q;
    s_d.ff1 = d_in;
    s_d.ff2 = s_q.ff1;
    s_d.ff3 = s_q.ff2;
    for (int i = 0; i < W; i++) begin
      if (s_q.ff2[i] == s_q.ff3[i]) begin
        s_d.lvl[i] = s_q.ff3[i];
      end
    end
  end

  // State register.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level_out = s_q.lvl;

endmodule : rsoa_sync3
`default_nettype wire

// file: rtl/rsoa_run_counter.sv
`timescale 1ns/1ps
`default_nettype none
module rsoa_run_counter
  import rsoa_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         core_clk,
  input  wire logic         resetn,
  input  wire logic         clr,
  input  wire logic         inc,
  input  wire logic [W-1:0] limit,
  output logic              reached
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } rsoa_run_st_t;

  rsoa_run_st_t s_q;
  rsoa_run_st_t s_d;

  // ==========================================================
  // Saturating run counter, a clear wins over a count.
  // ==========================================================
  always_comb begin
    s_d = s_q;
    if (clr) begin
      s_d.cnt = '0;
    end else if (inc && (s_q.cnt < limit)) begin
      s_d.cnt = s_q.cnt + W'(1);
    end
  end

  // State register.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign reached = (s_q.cnt >= limit);

endmodule : rsoa_run_counter
`default_nettype wire

// file: rtl/rsoa_rx_out.sv
`timescale 1ns/1ps
`default_nettype none
module rsoa_rx_out
  import rsoa_pkg::*;
#(
  parameter int unsigned LOS_6312_CYCLES = LOS_6312_CYC
) (
  input  wire logic              core_clk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire rsoa_line_t        line_in,
  output logic                   rx_clk_out,
  output logic                   rx_serial_out,
  output logic                   rx_boundary_pulse_out,
  output logic                   frame_loss_out,
  output logic                   signal_loss_out,
  output logic                   alarm_indication_out,
  output logic                   rx_pins_oe,
  output logic                   irq_out
);

  // ==========================================================
  // State.
  // ==========================================================
  typedef struct packed {
    rsoa_bus_st_t bus_st;
    logic         waitreq;
    logic [31:0]  rdata;
    rsoa_ctrl_t   ctrl;
    rsoa_alarm_t  int_stat;
    rsoa_alarm_t  int_mask;
    rsoa_alarm_t  alarm;
    logic         irq;
    logic         clk_prev;
    logic         transmit_clock_in_prev;
    logic [7:0]   scale_cnt;
    logic         tick;
    logic         extend;
    logic         rclk;
    logic         ser;
    logic         sync;
    logic         oe;
  } rsoa_st_t;

  rsoa_st_t    s_q;
  rsoa_st_t    s_d;
  rsoa_line_t  ln;
  logic        line_rise;
  logic        transmit_clock_in_edge;
  logic        is_6312;
  logic        is_t1;
  logic        zrun_hit;
  logic        tmr_hit;
  logic        transmit_clock_loss_hit;
  logic [ZRUN_W-1:0] zrun_limit;
  rsoa_alarm_t alarm_now;
  rsoa_alarm_t rd_clr;
  logic [31:0] rd_mux;
  logic        dbl_frame;

  // ==========================================================
  // Input synchronisation and run counters.
  // ==========================================================
  rsoa_sync3 #(
    .W (LINE_W)
  ) u_sync (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .d_in      (line_in),
    .level_out (ln)
  );

  // Consecutive zeros counted on recovered clock edges.
  rsoa_run_counter #(
    .W (ZRUN_W)
  ) u_zrun (
    .core_clk (core_clk),
    .resetn   (resetn),
    .clr      (line_rise && ln.data),
    .inc      (line_rise && !ln.data),
    .limit    (zrun_limit),
    .reached  (zrun_hit)
  );

  // Zero time in 6312 kHz mode, counted in core cycles.
  rsoa_run_counter #(
    .W (TMR_W)
  ) u_ztime (
    .core_clk (core_clk),
    .resetn   (resetn),
    .clr      (line_rise && ln.data),
    .inc      (1'b1),
    .limit    (TMR_W'(LOS_6312_CYCLES)),
    .reached  (tmr_hit)
  );

  // Scaled master clock periods since the last transmit clock transition.
  rsoa_run_counter #(
    .W (TRANSMIT_CLOCK_LOSS_W)
  ) u_transmit_clock_loss (
    .core_clk (core_clk),
    .resetn   (resetn),
    .clr      (transmit_clock_in_edge),
    .inc      (s_q.tick),
    .limit    (TRANSMIT_CLOCK_LOSS_PERIODS),
    .reached  (transmit_clock_loss_hit)
  );

  // Mode decode and edge detection.
  assign is_6312    = s_q.ctrl.mode[1];
  assign is_t1      = (s_q.ctrl.mode == RSOA_MODE_T1);
  assign zrun_limit = is_t1 ? T1_LOS_ZEROS : E1_LOS_ZEROS;
  assign line_rise  = ln.clk && !s_q.clk_prev;
  assign transmit_clock_in_edge  = ln.transmit_clock_in != s_q.transmit_clock_in_prev;
  assign dbl_frame  = is_t1 && !s_q.ctrl.boundary_select_bit
                      && s_q.ctrl.signaling_double_pulse_bit;

  // Register read multiplexer.
  always_comb begin
    rd_mux = '0;
    case (avs_address)
      REG_CTRL:     rd_mux[CTRL_W-1:0]  = s_q.ctrl;
      REG_LIVE:     rd_mux[ALARM_W-1:0] = s_q.alarm;
      REG_INT_STAT: rd_mux[ALARM_W-1:0] = s_q.int_stat;
      REG_INT_MASK: rd_mux[ALARM_W-1:0] = s_q.int_mask;
      default:      rd_mux = '0;
    endcase
  end

  // ==========================================================
  // Next-state logic.
  // ==========================================================
  always_comb begin
    s_d    = s_q;
    rd_clr = '0;

    // Avalon slave: waitrequest drops one cycle after the request.
    case (s_q.bus_st)
      RSOA_BUS_IDLE: begin
        if (avs_read || avs_write) begin
          s_d.bus_st  = RSOA_BUS_ANSWER;
          s_d.waitreq = 1'b0;
          s_d.rdata   = avs_read ? rd_mux : '0;
        end
      end
      RSOA_BUS_ANSWER: begin
        s_d.bus_st  = RSOA_BUS_IDLE;
        s_d.waitreq = 1'b1;
        if (avs_write && avs_byteenable[0]) begin
          if (avs_address == REG_CTRL) begin
            s_d.ctrl = rsoa_ctrl_t'(avs_writedata[CTRL_W-1:0]);
          end else if (avs_address == REG_INT_MASK) begin
            s_d.int_mask = rsoa_alarm_t'(avs_writedata[ALARM_W-1:0]);
          end
        end
        if (avs_read && (avs_address == REG_INT_STAT)) begin
          rd_clr = rsoa_alarm_t'(s_q.rdata[ALARM_W-1:0]);
        end
      end
      default: begin
        s_d.bus_st  = RSOA_BUS_IDLE;
        s_d.waitreq = 1'b1;
      end
    endcase

    // Scaled master clock enable.
    s_d.tick = 1'b0;
    if (s_q.scale_cnt == SCALE_DIV - 8'h01) begin
      s_d.scale_cnt = '0;
      s_d.tick      = 1'b1;
    end else begin
      s_d.scale_cnt = s_q.scale_cnt + 8'h01;
    end

    s_d.clk_prev  = ln.clk;
    s_d.transmit_clock_in_prev = ln.transmit_clock_in;
    s_d.rclk      = ln.clk;

    // Outside 6312 kHz mode, data and boundary pulse move only on recovered clock rises.
    if (line_rise) begin
      s_d.ser    = ln.data;
      s_d.extend = 1'b0;
      if (s_q.ctrl.boundary_select_bit) begin
        s_d.sync = ln.mframe_start;
      end else begin
        s_d.sync = ln.frame_start || s_q.extend;
        if (dbl_frame && ln.frame_start && ln.sig_frame) begin
          s_d.extend = 1'b1;
        end
      end
    end

    // Live conditions; each follows its cause and falls with it.
    alarm_now.frame_loss  = ln.searching;
    alarm_now.tx_clk_loss = transmit_clock_loss_hit;
    alarm_now.alarm_ind   = ln.ais;
    alarm_now.signal_loss = is_6312 ? tmr_hit : zrun_hit;
    s_d.alarm = alarm_now;

    // Sticky status: a new event wins over a clear by read.
    s_d.int_stat = (s_q.int_stat & ~rd_clr) | (alarm_now & ~s_q.alarm);
    s_d.irq      = |(s_d.int_stat & s_d.int_mask);

    // Pins float in 6312 kHz mode; serial data and boundary pulse are driven low behind the enable.
    s_d.oe = !is_6312;
    if (is_6312) begin
      s_d.ser  = 1'b0;
      s_d.sync = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_q          <= '0;
      s_q.bus_st   <= RSOA_BUS_IDLE;
      s_q.waitreq  <= 1'b1;
      s_q.ctrl     <= CTRL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Frame loss and alarm pins sit one cycle behind the live state, each in its own flop.
  logic flof_q;
  logic flof_d;
  logic aind_q;
  logic aind_d;
  always_comb begin
    flof_d = 1'b0;
    aind_d = 1'b0;
    if (!is_6312) begin
      flof_d = s_q.ctrl.frame_loss_function_select ?
               s_q.alarm.tx_clk_loss : s_q.alarm.frame_loss;
      aind_d = s_q.alarm.alarm_ind;
    end
  end

  // Pin registers, so no gate sits between a flop and the pin.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      flof_q <= 1'b0;
      aind_q <= 1'b0;
    end else begin
      flof_q <= flof_d;
      aind_q <= aind_d;
    end
  end

  // Outputs, each from a flip-flop.
  assign avs_readdata          = s_q.rdata;
  assign avs_waitrequest       = s_q.waitreq;
  assign rx_clk_out            = s_q.rclk;
  assign rx_serial_out         = s_q.ser;
  assign rx_boundary_pulse_out = s_q.sync;
  assign frame_loss_out        = flof_q;
  assign signal_loss_out       = s_q.alarm.signal_loss;
  assign alarm_indication_out  = aind_q;
  assign rx_pins_oe            = s_q.oe;
  assign irq_out               = s_q.irq;

  // ==========================================================
  // Assertions.
  // ==========================================================
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  chk_rclk_follow: assert property (
    rx_clk_out == $past(ln.clk)) else $error("recovered clock not copied");

  chk_sync_edge: assert property (
    !$stable(rx_boundary_pulse_out) && $past(!is_6312) |-> $past(line_rise))
    else $error("sync pulse moved off a clock rise");

  chk_double_pulse: assert property (
    line_rise && dbl_frame && ln.frame_start && ln.sig_frame && !is_6312
    |=> s_q.extend && rx_boundary_pulse_out)
    else $error("signaling frame not double wide");

  chk_pins_float: assert property (
    is_6312 |=> !rx_pins_oe && !rx_serial_out && !alarm_indication_out)
    else $error("pins driven in 6312 mode");

  chk_ser_edge: assert property (
    !$stable(rx_serial_out) && $past(!is_6312) |-> $past(line_rise))
    else $error("serial data moved off a clock rise");

  chk_lof_search: assert property (
    !is_6312 && !s_q.ctrl.frame_loss_function_select && $stable(s_q.ctrl)
    && s_q.alarm.frame_loss |=> frame_loss_out)
    else $error("frame loss not shown while searching");

  chk_transmit_clock_loss_flag: assert property (
    !is_6312 && s_q.ctrl.frame_loss_function_select && $stable(s_q.ctrl)
    && transmit_clock_loss_hit |=> ##1 frame_loss_out)
    else $error("transmit clock loss not shown");

  chk_los_t1: assert property (
    is_t1 && zrun_hit && $stable(s_q.ctrl) |=> signal_loss_out)
    else $error("T1 zero run not flagged");

  chk_los_e1: assert property (
    s_q.ctrl.mode == RSOA_MODE_E1 && zrun_hit && $stable(s_q.ctrl)
    |=> signal_loss_out) else $error("E1 zero run not flagged");

  chk_los_6312: assert property (
    is_6312 && tmr_hit && $stable(s_q.ctrl) |=> signal_loss_out)
    else $error("6312 zero time not flagged");

  chk_ais_follow: assert property (
    !is_6312 && $stable(s_q.ctrl) && $past(ln.ais) == ln.ais
    |=> alarm_indication_out == $past(ln.ais))
    else $error("alarm pin does not follow detection");

  chk_irq_level: assert property (
    ##1 irq_out == |($past(s_d.int_stat) & $past(s_d.int_mask)))
    else $error("interrupt level wrong");

  chk_lof_select: assert property (
    !is_6312 |=> frame_loss_out == ($past(s_q.ctrl.frame_loss_function_select) ?
                 $past(s_q.alarm.tx_clk_loss) : $past(s_q.alarm.frame_loss)))
    else $error("frame loss pin source wrong");

  chk_bus_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");

  cov_double: cover property (s_q.extend ##1 rx_boundary_pulse_out);
  cov_transmit_clock_loss: cover property (transmit_clock_loss_hit && frame_loss_out);
  cov_los: cover property (signal_loss_out ##[1:50] !signal_loss_out);
  cov_irq: cover property ($rose(irq_out));
  cov_float: cover property ($fell(rx_pins_oe));

endmodule : rsoa_rx_out
`default_nettype wire

// file: testbench/rsoa_line_model.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// Framer side line source.
// ====================
module rsoa_line_model
  import rsoa_pkg::*;
(
  input  wire logic        run,
  input  wire logic        tx_run,
  input  wire logic        force_zero,
  input  wire logic        searching,
  input  wire logic        ais,
  input  wire logic [31:0] pat,
  output var  rsoa_line_t  line_out
);
  logic       lc  = 1'b0;
  logic       txc = 1'b0;
  logic       dq  = 1'b0;
  logic [3:0] pos = 4'h0;
  logic [4:0] idx = 5'h0;
  logic [7:0] frm = 8'h0;

  // Line clock runs only in a burst and always stops low, off the core phase.
  initial begin
    #1.3;
    forever begin
      #40;
      if (run || lc) lc = !lc;
    end
  end

  // Transmit clock toggles while enabled, so its loss can be staged.
  initial begin
    forever begin
      #50.7;
      if (tx_run) txc = !txc;
    end
  end

  // Data and markers move on the falling edge; frames are twelve bits long.
  always @(negedge lc) begin
    dq  <= !force_zero && pat[idx];
    idx <= idx + 5'h1;
    pos <= (pos == 4'hb) ? 4'h0 : pos + 4'h1;
    if (pos == 4'hb) frm <= frm + 8'h1;
  end

  // Pack the framer view onto the line bus.
  always_comb begin
    line_out = {txc, lc, dq, pos == 4'h0, pos == 4'h0 && frm[1:0] == 2'h0, frm[0], searching, ais};
  end
endmodule : rsoa_line_model
`default_nettype wire

// file: testbench/rsoa_rx_out_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module rsoa_rx_out_tb_top
  import rsoa_pkg::*;
;
  logic              core_clk, resetn, avs_read, avs_write, avs_waitrequest, rd_chk;
  logic [ADDR_W-1:0] avs_address;
  logic [31:0]       avs_writedata, avs_readdata, pat;
  logic [3:0]        avs_byteenable;
  rsoa_line_t        line_in;
  rsoa_ctrl_t        cfg;
  logic              rx_clk_out, rx_serial_out, rx_boundary_pulse_out, frame_loss_out;
  logic              signal_loss_out, alarm_indication_out, rx_pins_oe, irq_out;
  logic              run, tx_run, force_zero, searching, ais, clk_prev, pfs, psig, e_sync;
  logic [1:0]        e_st;
  logic [31:0]       exp_q[$];
  logic [1:0]        sq[$];
  int                err_total, checked, cyc;

  rsoa_rx_out #(.LOS_6312_CYCLES(200)) i_dut (.core_clk, .resetn, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .line_in,
    .rx_clk_out, .rx_serial_out, .rx_boundary_pulse_out, .frame_loss_out, .signal_loss_out,
    .alarm_indication_out, .rx_pins_oe, .irq_out);
  rsoa_line_model i_line (.run, .tx_run, .force_zero, .searching, .ais, .pat, .line_out(line_in));

  // ====================
  // Checking and bus tasks.
  // ====================
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic chk1(input logic seen, input logic exp);
    chk({31'h0, seen}, {31'h0, exp});
  endtask : chk1

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim

  // One access, held until the edge that samples waitrequest low.
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     input logic [3:0] be, input logic ck);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= !wr;
    rd_chk         <= ck;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    if (n >= 64) chk(32'h0, 32'h1);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task automatic rd(input logic [ADDR_W-1:0] a, input logic ck, input logic [31:0] e);
    if (ck) exp_q.push_back(e);
    bus(1'b0, a, 32'h0, 4'hf, ck);
  endtask : rd

  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk);
  endtask : wait_clk

  // Ends a burst on a frame edge so no double pulse is left pending.
  task automatic stop_line();
    do @(posedge line_in.clk); while (line_in.frame_start !== 1'b1);
    repeat (47) @(posedge line_in.clk);
    run = 1'b0;
    wait_clk(40);
  endtask : stop_line

  task automatic flags(input logic on);
    searching <= 1'b1;
    ais       <= 1'b1;
    wait_clk(12);
    chk1(frame_loss_out, on);
    chk1(alarm_indication_out, on);
    chk1(rx_pins_oe, on);
    searching <= 1'b0;
    ais       <= 1'b0;
    wait_clk(12);
    chk1(frame_loss_out, 1'b0);
    chk1(alarm_indication_out, 1'b0);
  endtask : flags

  // Zero run of n line bits in T1 or E1 mode: low one bit short, high on the last one.
  task automatic los_run(input rsoa_mode_t m, input int n);
    cfg      = '0;
    cfg.mode = m;
    bus(1'b1, REG_CTRL, 32'(cfg), 4'hf, 1'b0);
    pat = 32'hffffffff;
    run = 1'b1;
    repeat (40) @(posedge line_in.clk);
    chk1(signal_loss_out, 1'b0);
    force_zero = 1'b1;
    if (m == RSOA_MODE_6312) begin
      @(negedge line_in.clk);
      wait_clk(150);
      chk1(signal_loss_out, 1'b0);
      wait_clk(80);
    end else begin
      repeat (n - 1) @(posedge line_in.clk);
      wait_clk(12);
      chk1(signal_loss_out, 1'b0);
      @(posedge line_in.clk);
      wait_clk(12);
    end
    chk1(signal_loss_out, 1'b1);
    force_zero = 1'b0;
    repeat (4) @(posedge line_in.clk);
    wait_clk(12);
    chk1(signal_loss_out, 1'b0);
    stop_line();
  endtask : los_run

  // ====================
  // Clock, expectations and monitor.
  // ====================
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Note what each line clock rise must produce at the pins.
  always @(posedge line_in.clk) begin
    e_sync = cfg.boundary_select_bit ? line_in.mframe_start : line_in.frame_start;
    if (cfg.mode == RSOA_MODE_T1 && !cfg.boundary_select_bit &&
        cfg.signaling_double_pulse_bit && pfs && psig) e_sync = 1'b1;
    sq.push_back(cfg.mode[1] ? 2'b00 : {line_in.data, e_sync});
    pfs  = line_in.frame_start;
    psig = line_in.sig_frame;
  end

  // Compare pins mid bit, read data at the answer edge, and bound the run.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 100000) begin
      err_total++;
      end_sim();
    end
    if (clk_prev === 1'b1 && rx_clk_out === 1'b0) begin
      chk1(sq.size() > 0, 1'b1);
      if (sq.size() > 0) begin
        e_st = sq.pop_front();
        chk1(rx_serial_out, e_st[1]);
        chk1(rx_boundary_pulse_out, e_st[0]);
        chk1(rx_pins_oe, !cfg.mode[1]);
      end
    end
    clk_prev <= rx_clk_out;
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && rd_chk === 1'b1)
      chk(avs_readdata, exp_q.size() > 0 ? exp_q.pop_front() : 32'hdead);
  end

  // ====================
  // Main sequence.
  // ====================
  initial begin
    {resetn, avs_read, avs_write, rd_chk, run, force_zero, searching, ais} = '0;
    {pfs, psig, clk_prev} = '0;
    {avs_address, avs_writedata, avs_byteenable, cyc, err_total, checked} = '0;
    tx_run = 1'b1;
    pat    = 32'hffffffff;
    cfg    = '0;
    void'($urandom(96372));
    wait_clk(16);
    resetn <= 1'b1;
    rd(REG_CTRL, 1'b1, 32'h0);
    rd(REG_INT_MASK, 1'b1, 32'h0);
    rd(REG_INT_STAT, 1'b1, 32'h0);
    rd(4'h2, 1'b1, 32'h0);
    bus(1'b1, REG_CTRL, 32'h1, 4'he, 1'b0);
    rd(REG_CTRL, 1'b1, 32'h0);
    $display("test registers finished");
    ais <= 1'b1;
    wait_clk(12);
    chk1(irq_out, 1'b0);
    rd(REG_LIVE, 1'b1, 32'h4);
    bus(1'b1, REG_LIVE, 32'h0, 4'hf, 1'b0);
    rd(REG_LIVE, 1'b1, 32'h4);
    rd(REG_INT_STAT, 1'b1, 32'h4);
    rd(REG_INT_STAT, 1'b1, 32'h0);
    bus(1'b1, REG_INT_MASK, 32'h4, 4'hf, 1'b0);
    rd(REG_INT_MASK, 1'b1, 32'h4);
    ais <= 1'b0;
    wait_clk(12);
    ais <= 1'b1;
    wait_clk(12);
    chk1(irq_out, 1'b1);
    rd(REG_INT_STAT, 1'b1, 32'h4);
    wait_clk(4);
    chk1(irq_out, 1'b0);
    ais <= 1'b0;
    $display("test interrupt finished");
    for (int i = 0; i < 16; i++) begin
      cfg = rsoa_ctrl_t'(i);
      pat = $urandom;
      bus(1'b1, REG_CTRL, 32'(cfg), 4'hf, 1'b0);
      rd(REG_CTRL, 1'b1, 32'(cfg));
      run = 1'b1;
      stop_line();
    end
    $display("test stream finished");
    los_run(RSOA_MODE_T1, 192);
    flags(1'b1);
    los_run(RSOA_MODE_E1, 255);
    flags(1'b1);
    los_run(RSOA_MODE_6312, 0);
    flags(1'b0);
    $display("test alarms finished");
    cfg = '0;
    cfg.frame_loss_function_select = 1'b1;
    bus(1'b1, REG_CTRL, 32'(cfg), 4'hf, 1'b0);
    searching <= 1'b1;
    wait_clk(20);
    chk1(frame_loss_out, 1'b0);
    searching <= 1'b0;
    tx_run    <= 1'b0;
    wait_clk(13 * 122);
    chk1(frame_loss_out, 1'b0);
    wait_clk(3 * 122 + 20);
    chk1(frame_loss_out, 1'b1);
    tx_run <= 1'b1;
    wait_clk(30);
    chk1(frame_loss_out, 1'b0);
    $display("test clock loss finished");
    chk(sq.size(), 32'h0);
    end_sim();
  end
endmodule : rsoa_rx_out_tb_top
`default_nettype wire
